// ### cme_pkg.sv
// Purpose: Shared constants and types for the command message encoder.
// Assumes: System clock at CME_CLK_HZ, bit clock supplied on its own port.
// Notes:   Tone frequencies are carried for the analog tone generator.
package cme_pkg;

	localparam int unsigned CME_CLK_HZ        = 40_000_000;
	localparam int unsigned CME_BIT_HZ        = 128;
	localparam int unsigned CME_CMD_BITS      = 8;
	localparam int unsigned CME_ADDR_BITS     = 8;
	localparam int unsigned CME_TIME_BITS     = 30;
	localparam int unsigned CME_INTRO_MIN     = 27;
	localparam int unsigned CME_SYNC_BITS     = 2;
	localparam int unsigned CME_MSG_BITS      = 45;
	localparam int unsigned CME_LOOP_LAT      = 3;

	// Clear interrupt timing, in milliseconds; CME_CLEAR_CYC in system clock cycles.
	localparam int unsigned CME_CLEAR_MS      = 325;
	localparam int unsigned CME_CLEAR_TOL_MS  = 175;
	localparam int unsigned CME_MS_PER_S      = 1000;
	localparam int unsigned CME_CLEAR_CYC     = CME_CLEAR_MS * (CME_CLK_HZ / CME_MS_PER_S);

	// Tone plan in hertz, held to within one part in ten thousand; AM depth in percent.
	localparam int unsigned CME_ONE_TONE_HZ   = 8600;
	localparam int unsigned CME_ZERO_TONE_HZ  = 7400;
	localparam int unsigned CME_EXEC_TONE_HZ  = 5790;
	localparam int unsigned CME_AM_DEPTH_PCT  = 50;

	// Command sources.
	localparam logic [1:0] CME_SRC_MANUAL     = 2'h0;
	localparam logic [1:0] CME_SRC_PRESET     = 2'h1;
	localparam logic [1:0] CME_SRC_COMPUTER   = 2'h2;

	typedef enum logic [1:0] {
		CME_TONE_OFF  = 2'b00,
		CME_TONE_ZERO = 2'b01,
		CME_TONE_ONE  = 2'b10,
		CME_TONE_EXEC = 2'b11
	} cme_tone_t;

	typedef enum logic [3:0] {
		CME_ST_IDLE  = 4'b0000,
		CME_ST_INTRO = 4'b0001,
		CME_ST_SYNC1 = 4'b0010,
		CME_ST_SYNC0 = 4'b0011,
		CME_ST_ADDR  = 4'b0100,
		CME_ST_CMD   = 4'b0101,
		CME_ST_HOLD  = 4'b0110,
		CME_ST_EXEC  = 4'b0111,
		CME_ST_CLEAR = 4'b1000
	} cme_state_t;

endpackage

// ### cme_cmd_logger.sv
// Purpose: Holds one log record (command, address, time) for the printer.
// Assumes: Printer handshake runs on the system clock.
// Notes:   A record not yet taken is overwritten and flagged as overrun.
`timescale 1ns/1ps
`default_nettype none
module cme_cmd_logger
	import cme_pkg::*;
(
	input  wire logic                     mclk_in,
	input  wire logic                     rstn_in,
	input  wire logic                     capture_in,
	input  wire logic [CME_CMD_BITS-1:0]  cmd_in,
	input  wire logic [CME_ADDR_BITS-1:0] addr_in,
	input  wire logic [CME_TIME_BITS-1:0] time_in,
	input  wire logic                     log_ack_in,
	output logic                          log_valid_out,
	output logic [CME_CMD_BITS-1:0]       log_cmd_out,
	output logic [CME_ADDR_BITS-1:0]      log_addr_out,
	output logic [CME_TIME_BITS-1:0]      log_time_out,
	output logic                          log_overrun_out
);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			log_cmd_out  <= '0;
			log_addr_out <= '0;
			log_time_out <= '0;
		end else if (capture_in) begin
			log_cmd_out  <= cmd_in;
			log_addr_out <= addr_in;
			log_time_out <= time_in;
		end
	end

	// A new capture wins over an acknowledge in the same cycle.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			log_valid_out <= 1'b0;
		end else if (capture_in) begin
			log_valid_out <= 1'b1;
		end else if (log_ack_in) begin
			log_valid_out <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			log_overrun_out <= 1'b0;
		end else if (capture_in && log_valid_out && !log_ack_in) begin
			log_overrun_out <= 1'b1;
		end else if (log_ack_in) begin
			log_overrun_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### cme_encoder.sv
// Purpose: Command message encoder sequencer with clear, execute and verification.
// Assumes: Bit clock on bit_clk_in runs free; all pins but log_ack_in are asynchronous to both clocks.
// Notes:   Tone outputs are codes for the analog generator, not waveforms.
`timescale 1ns/1ps
`default_nettype none
module cme_encoder
	import cme_pkg::*;
#(
	parameter int unsigned INTRO_BITS = CME_INTRO_MIN,
	parameter int unsigned CLEAR_CYC  = CME_CLEAR_CYC,
	parameter int unsigned LOOP_LAT   = CME_LOOP_LAT
)(
	input  wire logic                     mclk_in,
	input  wire logic                     rstn_in,
	input  wire logic                     bit_clk_in,
	input  wire logic [1:0]               src_sel_in,
	input  wire logic [CME_CMD_BITS-1:0]  manual_cmd_in,
	input  wire logic [CME_CMD_BITS-1:0]  preset_cmd_in,
	input  wire logic [CME_CMD_BITS-1:0]  computer_cmd_in,
	input  wire logic [CME_ADDR_BITS-1:0] decoder_addr_in,
	input  wire logic                     start_in,
	input  wire logic                     ctrl_clear_in,
	input  wire logic                     panel_clear_in,
	input  wire logic                     ctrl_exec_in,
	input  wire logic                     sdb_exec_in,
	input  wire logic                     ctrl_override_in,
	input  wire logic                     manual_override_in,
	input  wire logic                     exec_am_sel_in,
	input  wire logic                     loopback_bit_in,
	input  wire logic [CME_CMD_BITS-1:0]  tlm_cmd_in,
	input  wire logic                     tlm_valid_in,
	input  wire logic [CME_TIME_BITS-1:0] time_bcd_in,
	input  wire logic                     log_ack_in,
	output logic [1:0]                    tone_sel_out,
	output logic                          tone_am_out,
	output logic                          nrz_bit_out,
	output logic                          busy_out,
	output logic                          clear_active_out,
	output logic [CME_CMD_BITS-1:0]       cmd_display_out,
	output logic                          loop_data_out,
	output logic                          gnd_verify_err_out,
	output logic                          tlm_match_out,
	output logic                          tlm_mismatch_out,
	output logic                          log_valid_out,
	output logic [CME_CMD_BITS-1:0]       log_cmd_out,
	output logic [CME_ADDR_BITS-1:0]      log_addr_out,
	output logic [CME_TIME_BITS-1:0]      log_time_out,
	output logic                          log_overrun_out
);

	localparam int unsigned CLR_W = $clog2(CLEAR_CYC + 1);
	localparam int unsigned CNT_W = $clog2(INTRO_BITS + 1);
	localparam int unsigned SW_W  = 2 + 4 * CME_CMD_BITS + CME_ADDR_BITS
	                              + CME_TIME_BITS + 6;

	// System clock domain: pin synchronisers. Switch banks are static while sampled.
	logic [SW_W-1:0] sw_s1_q;
	logic [SW_W-1:0] sw_s2_q;
	logic [1:0]      src_s;
	logic [CME_CMD_BITS-1:0]  man_s;
	logic [CME_CMD_BITS-1:0]  pre_s;
	logic [CME_CMD_BITS-1:0]  comp_s;
	logic [CME_ADDR_BITS-1:0] addr_s;
	logic [CME_CMD_BITS-1:0]  tlm_s;
	logic [CME_TIME_BITS-1:0] time_s;
	logic start_s;
	logic cclr_s;
	logic pclr_s;
	logic tlmv_s;
	logic covr_s;
	logic movr_s;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sw_s1_q <= '0;
			sw_s2_q <= '0;
		end else begin
			sw_s1_q <= {src_sel_in, manual_cmd_in, preset_cmd_in, computer_cmd_in,
			            decoder_addr_in, tlm_cmd_in, time_bcd_in, start_in, ctrl_clear_in,
			            panel_clear_in, tlm_valid_in, ctrl_override_in, manual_override_in};
			sw_s2_q <= sw_s1_q;
		end
	end

	assign {src_s, man_s, pre_s, comp_s, addr_s, tlm_s, time_s,
	        start_s, cclr_s, pclr_s, tlmv_s, covr_s, movr_s} = sw_s2_q;

	function automatic logic [CME_CMD_BITS-1:0] pick_cmd(
		input logic [1:0] sel,
		input logic [CME_CMD_BITS-1:0] man,
		input logic [CME_CMD_BITS-1:0] pre,
		input logic [CME_CMD_BITS-1:0] comp);
		logic [CME_CMD_BITS-1:0] r;
		r = man;
		if (sel == CME_SRC_PRESET) begin
			r = pre;
		end else if (sel == CME_SRC_COMPUTER) begin
			r = comp;
		end
		return r;
	endfunction

	// Edge detectors on synchronised levels.
	logic start_d1_q;
	logic clr_d1_q;
	logic tlmv_d1_q;
	logic clr_req;
	logic start_ok;
	logic tlm_evt;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			start_d1_q <= 1'b0;
			clr_d1_q   <= 1'b0;
			tlmv_d1_q  <= 1'b0;
		end else begin
			start_d1_q <= start_s;
			clr_d1_q   <= cclr_s | pclr_s;
			tlmv_d1_q  <= tlmv_s;
		end
	end

	assign clr_req = (cclr_s | pclr_s) & ~clr_d1_q;
	assign tlm_evt = tlmv_s & ~tlmv_d1_q;

	// Clear timer: holds the tone interrupt for the nominal clear length.
	logic [CLR_W-1:0] clr_cnt_q;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clr_cnt_q <= '0;
		end else if (clr_req) begin
			clr_cnt_q <= CLR_W'(CLEAR_CYC);
		end else if (clr_cnt_q != '0) begin
			clr_cnt_q <= clr_cnt_q - 1'b1;
		end
	end

	assign clear_active_out = (clr_cnt_q != '0);

	// Start handshake toward the bit clock domain.
	logic       start_tgl_q;
	logic       pend_q;
	logic [1:0] busy_sy_q;

	assign busy_out = pend_q | busy_sy_q[1];
	assign start_ok = start_s & ~start_d1_q & ~busy_out & ~clear_active_out;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			start_tgl_q <= 1'b0;
		end else if (start_ok) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// Pending covers the crossing delay until the link reports busy.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pend_q <= 1'b0;
		end else if (start_ok) begin
			pend_q <= 1'b1;
		end else if (busy_sy_q[1] || clear_active_out) begin
			pend_q <= 1'b0;
		end
	end

	// Command and address stay frozen while busy, so the link reads them safely.
	logic [CME_CMD_BITS-1:0]  cmd_q;
	logic [CME_ADDR_BITS-1:0] addr_q;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd_q  <= '0;
			addr_q <= '0;
		end else if (start_ok) begin
			cmd_q  <= pick_cmd(src_s, man_s, pre_s, comp_s);
			addr_q <= addr_s;
		end
	end

	assign cmd_display_out = cmd_q;

	// Telemetry verification; a new report wins over the clear at start.
	logic match_q;
	logic mism_q;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			match_q <= 1'b0;
			mism_q  <= 1'b0;
		end else if (tlm_evt) begin
			match_q <= (tlm_s == cmd_q);
			mism_q  <= (tlm_s != cmd_q);
		end else if (start_ok) begin
			match_q <= 1'b0;
			mism_q  <= 1'b0;
		end
	end

	assign tlm_match_out    = match_q;
	assign tlm_mismatch_out = mism_q;

	cme_cmd_logger u_logger (
		.mclk_in         (mclk_in),
		.rstn_in         (rstn_in),
		.capture_in      (start_ok),
		.cmd_in          (pick_cmd(src_s, man_s, pre_s, comp_s)),
		.addr_in         (addr_s),
		.time_in         (time_s),
		.log_ack_in      (log_ack_in),
		.log_valid_out   (log_valid_out),
		.log_cmd_out     (log_cmd_out),
		.log_addr_out    (log_addr_out),
		.log_time_out    (log_time_out),
		.log_overrun_out (log_overrun_out)
	);

	// Bit clock domain. Execute gates and operator setting are pins; permit and
	// clear are system levels; all pass two flip-flops here.
	logic [6:0] lk_s1_q;
	logic [6:0] lk_s2_q;
	logic       go_d_q;
	logic       permit;

	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lk_s1_q <= '0;
			lk_s2_q <= '0;
			go_d_q  <= 1'b0;
		end else begin
			lk_s1_q <= {start_tgl_q, clear_active_out, match_q | covr_s | movr_s,
			            ctrl_exec_in, sdb_exec_in, exec_am_sel_in, loopback_bit_in};
			lk_s2_q <= lk_s1_q;
			go_d_q  <= lk_s2_q[6];
		end
	end

	logic go;
	logic clr_l;
	logic gate;
	logic am_sel_l;
	logic loop_l;

	assign go       = lk_s2_q[6] ^ go_d_q;
	assign clr_l    = lk_s2_q[5];
	assign permit   = lk_s2_q[4];
	assign gate     = lk_s2_q[3] | lk_s2_q[2];
	assign am_sel_l = lk_s2_q[1];
	assign loop_l   = lk_s2_q[0];

	cme_state_t st_q;
	cme_state_t st_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CME_CMD_BITS+CME_ADDR_BITS-1:0] sh_q;

	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q + 1'b1;
		unique case (st_q)
			CME_ST_IDLE: begin
				cnt_d = '0;
				if (go) begin
					st_d = CME_ST_INTRO;
				end
			end
			CME_ST_INTRO: begin
				if (cnt_q == CNT_W'(INTRO_BITS - 1)) begin
					st_d  = CME_ST_SYNC1;
					cnt_d = '0;
				end
			end
			CME_ST_SYNC1: st_d = CME_ST_SYNC0;
			CME_ST_SYNC0: begin
				st_d  = CME_ST_ADDR;
				cnt_d = '0;
			end
			CME_ST_ADDR: begin
				if (cnt_q == CNT_W'(CME_ADDR_BITS - 1)) begin
					st_d  = CME_ST_CMD;
					cnt_d = '0;
				end
			end
			CME_ST_CMD: begin
				if (cnt_q == CNT_W'(CME_CMD_BITS - 1)) begin
					st_d = CME_ST_HOLD;
				end
			end
			CME_ST_HOLD: begin
				cnt_d = '0;
				if (gate && permit) begin
					st_d = CME_ST_EXEC;
				end
			end
			CME_ST_EXEC: begin
				cnt_d = '0;
				if (!gate) begin
					st_d = CME_ST_HOLD;
				end
			end
			CME_ST_CLEAR: begin
				cnt_d = '0;
				if (!clr_l) begin
					st_d = CME_ST_IDLE;
				end
			end
			default: begin
				st_d  = CME_ST_IDLE;
				cnt_d = '0;
			end
		endcase
		if (clr_l && st_q != CME_ST_CLEAR) begin
			st_d  = CME_ST_CLEAR;
			cnt_d = '0;
		end
	end

	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q  <= CME_ST_IDLE;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Address and command shift out MSB first as one register.
	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sh_q <= '0;
		end else if (st_q == CME_ST_IDLE && go) begin
			sh_q <= {addr_q, cmd_q};
		end else if (st_d == CME_ST_CMD || (st_q == CME_ST_ADDR || st_q == CME_ST_CMD)) begin
			if (st_q == CME_ST_ADDR || st_q == CME_ST_CMD) begin
				sh_q <= {sh_q[CME_CMD_BITS+CME_ADDR_BITS-2:0], 1'b0};
			end
		end
	end

	// Bit presented for the current state.
	logic cur_bit;
	logic cur_data;

	always_comb begin
		cur_bit  = 1'b0;
		cur_data = 1'b1;
		unique case (st_q)
			CME_ST_SYNC1: cur_bit = 1'b1;
			CME_ST_ADDR:  cur_bit = sh_q[CME_CMD_BITS+CME_ADDR_BITS-1];
			CME_ST_CMD:   cur_bit = sh_q[CME_CMD_BITS+CME_ADDR_BITS-1];
			CME_ST_IDLE:  cur_data = 1'b0;
			CME_ST_EXEC:  cur_data = 1'b0;
			CME_ST_CLEAR: cur_data = 1'b0;
			default:      cur_bit = 1'b0;
		endcase
	end

	assign nrz_bit_out = cur_bit;

	always_comb begin
		tone_sel_out = CME_TONE_OFF;
		tone_am_out  = 1'b0;
		if (st_q == CME_ST_EXEC) begin
			tone_sel_out = CME_TONE_EXEC;
			tone_am_out  = am_sel_l;
		end else if (cur_data) begin
			tone_sel_out = cur_bit ? CME_TONE_ONE : CME_TONE_ZERO;
			tone_am_out  = 1'b1;
		end
	end

	// Loopback check: the demodulated bit returns LOOP_LAT bit periods late.
	logic [LOOP_LAT-1:0] hist_bit_q;
	logic [LOOP_LAT-1:0] hist_val_q;
	logic                gnd_err_q;
	logic                loop_q;

	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hist_bit_q <= '0;
			hist_val_q <= '0;
			loop_q     <= 1'b0;
		end else begin
			hist_bit_q <= {hist_bit_q[LOOP_LAT-2:0], cur_bit};
			hist_val_q <= {hist_val_q[LOOP_LAT-2:0], cur_data};
			loop_q     <= loop_l;
		end
	end

	// A mismatch seen in the start cycle still sets the flag.
	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			gnd_err_q <= 1'b0;
		end else if (hist_val_q[LOOP_LAT-1] && (hist_bit_q[LOOP_LAT-1] != loop_l)) begin
			gnd_err_q <= 1'b1;
		end else if (st_q == CME_ST_IDLE && go) begin
			gnd_err_q <= 1'b0;
		end
	end

	assign loop_data_out      = loop_q;
	assign gnd_verify_err_out = gnd_err_q;

	// Busy level returns to the system domain through busy_sy_q.
	logic busy_l_q;

	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_l_q <= 1'b0;
		end else begin
			busy_l_q <= (st_d != CME_ST_IDLE);
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_sy_q <= '0;
		end else begin
			busy_sy_q <= {busy_sy_q[0], busy_l_q};
		end
	end

endmodule
`default_nettype wire

// ### cme_top_note_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### cme_encoder_chk.sv
// Purpose: Port-level checks on the command message encoder.
// Assumes: The telemetry command is held steady around its valid strobe.
// Notes:   Bit-domain checks see one sample per bit period.
`timescale 1ns/1ps
`default_nettype none
module cme_encoder_chk
	import cme_pkg::*;
#(
	parameter int unsigned INTRO_BITS = CME_INTRO_MIN,
	parameter int unsigned CLEAR_CYC  = CME_CLEAR_CYC
)(
	input  wire logic                     mclk_in,
	input  wire logic                     rstn_in,
	input  wire logic                     bit_clk_in,
	input  wire logic                     ctrl_exec_in,
	input  wire logic                     sdb_exec_in,
	input  wire logic                     ctrl_override_in,
	input  wire logic                     manual_override_in,
	input  wire logic [CME_CMD_BITS-1:0]  tlm_cmd_in,
	input  wire logic [CME_ADDR_BITS-1:0] decoder_addr_in,
	input  wire logic [1:0]               tone_sel_out,
	input  wire logic                     tone_am_out,
	input  wire logic                     nrz_bit_out,
	input  wire logic                     busy_out,
	input  wire logic                     clear_active_out,
	input  wire logic [CME_CMD_BITS-1:0]  cmd_display_out,
	input  wire logic                     tlm_match_out,
	input  wire logic                     log_valid_out,
	input  wire logic [CME_CMD_BITS-1:0]  log_cmd_out,
	input  wire logic [CME_ADDR_BITS-1:0] log_addr_out
);
	logic [31:0] clr_len_q;
	logic [7:0]  run_q;
	logic        intro_q;
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) clr_len_q <= '0;
		else if (clear_active_out) clr_len_q <= clr_len_q + 32'h1;
		else clr_len_q <= '0;
	end
	// Counts zero periods that follow silence, so only the introduction is measured.
	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			intro_q <= 1'h0;
			run_q   <= 8'h0;
		end else if (tone_sel_out == CME_TONE_OFF) begin
			intro_q <= 1'h1;
			run_q   <= 8'h0;
		end else if (intro_q && tone_sel_out == CME_TONE_ZERO) run_q <= run_q + 8'h1;
		else intro_q <= 1'h0;
	end
	chk_clear_length: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$fell(clear_active_out) |-> clr_len_q == CLEAR_CYC) else $error("clear length wrong");
	chk_clear_silent: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		clear_active_out [*5] |-> tone_sel_out == CME_TONE_OFF) else $error("tone during clear");
	chk_idle_silent: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!busy_out |-> tone_sel_out == CME_TONE_OFF) else $error("tone while idle");
	chk_intro_sync: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		(intro_q && tone_sel_out == CME_TONE_ONE) |-> run_q == INTRO_BITS
		##1 tone_sel_out == CME_TONE_ZERO) else $error("introduction or sync wrong");
	chk_nrz_tone: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		(tone_sel_out inside {CME_TONE_ZERO, CME_TONE_ONE})
		|-> nrz_bit_out == (tone_sel_out == CME_TONE_ONE)) else $error("tone and bit differ");
	chk_data_am: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		(tone_sel_out inside {CME_TONE_ZERO, CME_TONE_ONE}) |-> tone_am_out)
		else $error("data tone without modulation");
	chk_exec_gated: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		tone_sel_out == CME_TONE_EXEC |-> ($past(ctrl_exec_in || sdb_exec_in, 3)
		|| $past(ctrl_exec_in || sdb_exec_in, 4))) else $error("execute without gate");
	chk_exec_permit: assert property (@(posedge bit_clk_in) disable iff (!rstn_in)
		(tone_sel_out == CME_TONE_EXEC && $past(tone_sel_out) != CME_TONE_EXEC)
		|-> ($past(tlm_match_out || ctrl_override_in || manual_override_in, 3)
		|| $past(tlm_match_out || ctrl_override_in || manual_override_in, 4)))
		else $error("execute while inhibited");
	chk_log_record: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$rose(busy_out) |-> ##1 (log_valid_out && log_cmd_out == cmd_display_out
		&& log_addr_out == decoder_addr_in)) else $error("log record missing");
	chk_match_value: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$rose(tlm_match_out) |-> tlm_cmd_in == cmd_display_out) else $error("false match");
endmodule
bind cme_encoder cme_encoder_chk #(.INTRO_BITS(INTRO_BITS), .CLEAR_CYC(CLEAR_CYC)) u_chk (
	.mclk_in(mclk_in), .rstn_in(rstn_in), .bit_clk_in(bit_clk_in),
	.ctrl_exec_in(ctrl_exec_in), .sdb_exec_in(sdb_exec_in),
	.ctrl_override_in(ctrl_override_in), .manual_override_in(manual_override_in),
	.tlm_cmd_in(tlm_cmd_in), .decoder_addr_in(decoder_addr_in),
	.tone_sel_out(tone_sel_out), .tone_am_out(tone_am_out), .nrz_bit_out(nrz_bit_out),
	.busy_out(busy_out), .clear_active_out(clear_active_out),
	.cmd_display_out(cmd_display_out), .tlm_match_out(tlm_match_out),
	.log_valid_out(log_valid_out), .log_cmd_out(log_cmd_out), .log_addr_out(log_addr_out)
);
`default_nettype wire

// ### cme_link_partner.sv
// Purpose: Loopback demodulator standing for the modulator and receiver path.
// Assumes: Tone codes change on the bit clock.
// Notes:   The corrupt input inverts the returned bit to provoke a verify error.
`timescale 1ns/1ps
`default_nettype none
module cme_link_partner
	import cme_pkg::*;
(
	input  wire logic       bit_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       corrupt_in,
	input  wire logic [1:0] tone_sel_in,
	output logic            loopback_bit_out
);
	// One bit period of delay models the whole loop path.
	always_ff @(posedge bit_clk_in or negedge rstn_in) begin
		if (!rstn_in) loopback_bit_out <= 1'h0;
		else loopback_bit_out <= (tone_sel_in == CME_TONE_ONE) ^ corrupt_in;
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the command message encoder.
// Assumes: Clear interrupt shortened to a few hundred system cycles.
// Notes:   Tone codes are sampled mid bit period, away from the bit clock edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t ns: %h versus %h", $time, (a), (b)); end end
module tb_top import cme_pkg::*;;
	localparam int unsigned CLR = 200;
	logic        mclk_in, rstn_in, bit_clk_in, start, cclr, pclr, cexe, sexe, cov, mov;
	logic        am_sel, loop_bit, tlm_valid, log_ack, corrupt;
	logic [1:0]  src_sel, tone;
	logic [7:0]  man, pre, comp, addr, tlm_cmd, disp, lcmd, laddr;
	logic [29:0] time_bcd, ltime;
	logic        tone_am, nrz, busy, clr_act, loop_data, gerr, match, mism, lvalid, lover;
	int          n_fail, comparisons;
	cme_encoder #(.INTRO_BITS(CME_INTRO_MIN), .CLEAR_CYC(CLR)) uut (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .bit_clk_in(bit_clk_in), .src_sel_in(src_sel),
		.manual_cmd_in(man), .preset_cmd_in(pre), .computer_cmd_in(comp),
		.decoder_addr_in(addr), .start_in(start), .ctrl_clear_in(cclr), .panel_clear_in(pclr),
		.ctrl_exec_in(cexe), .sdb_exec_in(sexe), .ctrl_override_in(cov),
		.manual_override_in(mov), .exec_am_sel_in(am_sel), .loopback_bit_in(loop_bit),
		.tlm_cmd_in(tlm_cmd), .tlm_valid_in(tlm_valid), .time_bcd_in(time_bcd),
		.log_ack_in(log_ack), .tone_sel_out(tone), .tone_am_out(tone_am), .nrz_bit_out(nrz),
		.busy_out(busy), .clear_active_out(clr_act), .cmd_display_out(disp),
		.loop_data_out(loop_data), .gnd_verify_err_out(gerr), .tlm_match_out(match),
		.tlm_mismatch_out(mism), .log_valid_out(lvalid), .log_cmd_out(lcmd),
		.log_addr_out(laddr), .log_time_out(ltime), .log_overrun_out(lover));
	cme_link_partner u_partner (.bit_clk_in(bit_clk_in), .rstn_in(rstn_in),
		.corrupt_in(corrupt), .tone_sel_in(tone), .loopback_bit_out(loop_bit));
	initial begin
		mclk_in = 1'h0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// The bit clock is offset so its edges never meet the rising system clock edges.
	initial begin
		bit_clk_in = 1'h0;
		#7;
		forever #16 bit_clk_in = ~bit_clk_in;
	end
	task automatic complete_run();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wait_tone(input logic [1:0] v, input int n);
		for (int i = 0; i < n && tone !== v; i++) @(negedge bit_clk_in);
		`CHK(tone, v)
		if (tone !== v) complete_run();
	endtask
	task automatic wait_m(input logic which, input logic v, input int n);
		for (int i = 0; i < n && (which ? clr_act : busy) !== v; i++) @(negedge mclk_in);
		`CHK(which ? clr_act : busy, v)
		if ((which ? clr_act : busy) !== v) complete_run();
	endtask
	task automatic do_start(input logic [1:0] src);
		@(negedge mclk_in);
		src_sel <= src;
		start   <= 1'h1;
		for (int i = 0; i < 10 && busy !== 1'h1; i++) @(negedge mclk_in);
		start   <= 1'h0;
	endtask
	task automatic t_frame(input logic [1:0] src, input logic [7:0] c, input logic bad);
		logic [44:0] exp;
		exp = {27'h0, 2'h2, addr, c};
		corrupt <= bad;
		do_start(src);
		`CHK({busy, disp}, {1'h1, c})
		wait_tone(CME_TONE_ZERO, 20);
		for (int i = 44; i >= 0; i--) begin
			`CHK({tone, nrz, tone_am}, {exp[i] ? CME_TONE_ONE : CME_TONE_ZERO, exp[i], 1'h1})
			if (i <= 40) `CHK(loop_data, exp[i+4] ^ bad)
			@(negedge bit_clk_in);
		end
		repeat (3) begin
			`CHK(tone, CME_TONE_ZERO)
			@(negedge bit_clk_in);
		end
		`CHK(gerr, bad)
		@(negedge mclk_in);
		`CHK({lvalid, lcmd, laddr, ltime}, {1'h1, c, addr, time_bcd})
		log_ack <= 1'h1;
		@(negedge mclk_in);
		log_ack <= 1'h0;
		@(negedge mclk_in);
		`CHK(lvalid, 1'h0)
	endtask
	task automatic t_exec(input logic sdb, input logic am, input logic ok);
		@(negedge mclk_in);
		am_sel <= am;
		sexe   <= sdb;
		cexe   <= ~sdb;
		repeat (8) @(negedge bit_clk_in);
		`CHK(tone, ok ? CME_TONE_EXEC : CME_TONE_ZERO)
		if (ok) `CHK(tone_am, am)
		repeat (4) @(negedge bit_clk_in);
		`CHK(tone, ok ? CME_TONE_EXEC : CME_TONE_ZERO)
		@(negedge mclk_in);
		sexe <= 1'h0;
		cexe <= 1'h0;
		repeat (8) @(negedge bit_clk_in);
		`CHK(tone, CME_TONE_ZERO)
	endtask
	task automatic t_tlm(input logic [7:0] v, input logic m);
		@(negedge mclk_in);
		tlm_cmd <= v;
		@(negedge mclk_in);
		tlm_valid <= 1'h1;
		repeat (6) @(negedge mclk_in);
		tlm_valid <= 1'h0;
		`CHK({match, mism}, {m, ~m})
	endtask
	task automatic t_clear(input logic panel);
		int n;
		@(negedge mclk_in);
		pclr <= panel;
		cclr <= ~panel;
		wait_m(1'h1, 1'h1, 10);
		pclr <= 1'h0;
		cclr <= 1'h0;
		for (n = 0; n < CLR + 20 && clr_act === 1'h1; n++) begin
			if (n == 100) `CHK(tone, CME_TONE_OFF)
			@(negedge mclk_in);
		end
		`CHK(n, CLR)
		wait_m(1'h0, 1'h0, 40);
		`CHK(tone, CME_TONE_OFF)
	endtask
	initial begin
		{rstn_in, start, cclr, pclr, cexe, sexe, cov, mov, am_sel, tlm_valid} = '0;
		{log_ack, corrupt, src_sel, tlm_cmd} = '0;
		{man, pre, comp, addr, time_bcd} = {8'hA5, 8'h3C, 8'hC3, 8'h96, 30'h1234567};
		n_fail = 0;
		comparisons = 0;
		repeat (10) @(negedge mclk_in);
		rstn_in = 1'h1;
		@(negedge mclk_in);
		`CHK({tone, busy, clr_act, lvalid}, 5'h0)
		t_frame(CME_SRC_MANUAL, man, 1'h0);
		t_exec(1'h0, 1'h1, 1'h0);
		t_tlm(~man, 1'h0);
		t_tlm(man, 1'h1);
		t_exec(1'h0, 1'h1, 1'h1);
		t_exec(1'h1, 1'h0, 1'h1);
		t_clear(1'h1);
		t_frame(CME_SRC_PRESET, pre, 1'h1);
		mov <= 1'h1;
		t_exec(1'h1, 1'h1, 1'h1);
		mov <= 1'h0;
		cov <= 1'h1;
		t_exec(1'h0, 1'h0, 1'h1);
		cov <= 1'h0;
		t_clear(1'h0);
		do_start(CME_SRC_COMPUTER);
		`CHK(disp, comp)
		wait_tone(CME_TONE_ZERO, 20);
		t_clear(1'h0);
		complete_run();
	end
endmodule
`default_nettype wire
